// [hw/bwsmp_pkg.sv]
// Constants for the byte-wide mailbox port: offsets, fields, resets.
// Assumes one processor clock domain for all users of the package.
// Function
// - Local data reads return master-written bytes
// - Local data writes load outgoing slots
// - Master write byte0 sets status bit7
// - Local write byte0 sets status bit3
// - Status 6:4 flag full incoming slots
// - Status 2:0 flag full outgoing slots
// - Control bit7 disables boot-pin fetch control
// - Control 6:5 read boot pins, ignore writes
// - Mode 00 makes port A input
// - Mode 01 makes port A output
// - Mode 10 enables master mailbox access
// - Mode 11 enables external I/O bus
// - Control 1:0 sets write-only interrupt priority
// - Master write byte0 raises local interrupt unless priority is 00
// - Local write byte0 asserts attention output
// - Any mailbox access clears interrupt, attention
// - All operations synchronous to processor clock
package bwsmp_pkg;
    // Local register offsets
    localparam logic [7:0] DATA0_OFS   = 8'h20;
    localparam logic [7:0] DATA1_OFS   = 8'h21;
    localparam logic [7:0] DATA2_OFS   = 8'h22;
    localparam logic [7:0] STATUS_OFS  = 8'h23;
    localparam logic [7:0] CONTROL_OFS = 8'h24;
    localparam logic [7:0] PA_DATA_OFS = 8'h30;
    // Master-side register indices
    localparam logic [1:0] M_STATUS_IDX = 2'h3;
    // Status bit positions
    localparam int ST_MWROTE_BIT = 7;
    localparam int ST_IN_LSB     = 4;
    localparam int ST_LWROTE_BIT = 3;
    localparam int ST_OUT_LSB    = 0;
    // Control bit positions
    localparam int CT_NOFETCH_BIT = 7;
    localparam int CT_BOOT_LSB    = 5;
    localparam int CT_CSSEL_BIT   = 4;
    localparam int CT_MODE_LSB    = 2;
    localparam int CT_PRIO_LSB    = 0;
    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] DATA_RST    = 8'h00;
    // Write event queue shape
    localparam int EVQ_WIDTH = 10;
    localparam int EVQ_DEPTH = 16;
    // Port A modes
    typedef enum logic [1:0] {
        BWSMP_PA_IN,
        BWSMP_PA_OUT,
        BWSMP_SLAVE,
        BWSMP_EXT_BUS
    } bwsmp_mode_e;
endpackage

// [hw/bwsmp_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module bwsmp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////
    // Handshakes
    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_ff[rd_ptr_ff];

    // Storage
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [hw/bwsmp_top.sv]
// Byte-wide mailbox port between an external master and local software.
// Assumes master pins are asynchronous; local bus is on sys_clk.
`timescale 1ns/1ps
module bwsmp_top
    import bwsmp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] loc_addr,
    input  wire logic       loc_wr,
    input  wire logic       loc_rd,
    input  wire logic [7:0] loc_wdata,
    output logic      [7:0] loc_rdata_ff,
    input  wire logic       port_e_alt_pin,
    input  wire logic       port_b_alt_pin,
    input  wire logic [1:0] master_addr,
    input  wire logic       master_rd_n,
    input  wire logic       master_wr_n,
    input  wire logic [7:0] master_data_in,
    output logic      [7:0] master_data_out_ff,
    output logic            master_data_oe_ff,
    output logic            attention_out_n_ff,
    output logic            mailbox_irq_ff,
    output logic      [1:0] irq_priority_ff,
    output logic            wr_overrun_ff,
    input  wire logic [1:0] boot_mode_pins,
    output logic            fetch_by_pins_ff,
    input  wire logic [7:0] port_a_in,
    output logic      [7:0] port_a_out_ff,
    output logic            port_a_oe_ff,
    output logic      [5:0] port_b_addr_ff,
    output logic            port_b_addr_oe_ff
);
    // Pin synchronisers: stage 1 is read only by stage 2
    logic [23:0] pin_s1_ff;
    logic [23:0] pin_s2_ff;
    logic [7:0]  pa_s2;
    logic [1:0]  boot_s2;
    logic [7:0]  mdata_s2;
    logic [1:0]  maddr_s2;
    logic        rd_n_s2;
    logic        wr_n_s2;
    logic        cs_e_s2;
    logic        cs_b_s2;
    logic        rd_n_d_ff;
    logic        wr_n_d_ff;
    // Register state
    logic [7:0]  ctrl_ff;
    logic [7:0]  in_slot_ff  [3];
    logic [7:0]  out_slot_ff [3];
    logic [2:0]  in_full_ff;
    logic [2:0]  out_full_ff;
    logic        mwrote_ff;
    logic        lwrote_ff;
    logic [7:0]  status;
    // Decode
    bwsmp_mode_e mode;
    logic        cs_act;
    logic        m_wr_end;
    logic        m_rd_end;
    logic        m_rd_act;
    logic        loc_busy;
    logic        loc_mbx;
    logic [2:0]  loc_wr_slot;
    logic [2:0]  loc_rd_slot;
    logic        loc_wr_stat;
    logic        evq_in_ready;
    logic        evq_out_valid;
    logic [9:0]  evq_out_data;
    logic        ev_pop;
    logic [1:0]  ev_addr;
    logic [7:0]  ev_data;
    logic [2:0]  m_wr_slot;
    logic [2:0]  m_rd_slot;
    logic        m_wr_stat;
    logic        set_irq;
    logic        set_attn;
    logic        any_access;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage sync of every master and boot pin
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_ff <= 24'hff_ffff;
            pin_s2_ff <= 24'hff_ffff;
            rd_n_d_ff <= 1'b1;
            wr_n_d_ff <= 1'b1;
        end else begin
            pin_s1_ff <= {port_a_in, boot_mode_pins, master_data_in, master_addr,
                          master_rd_n, master_wr_n, port_e_alt_pin, port_b_alt_pin};
            pin_s2_ff <= pin_s1_ff;
            rd_n_d_ff <= rd_n_s2;
            wr_n_d_ff <= wr_n_s2;
        end
    end

    assign {pa_s2, boot_s2, mdata_s2, maddr_s2, rd_n_s2, wr_n_s2, cs_e_s2, cs_b_s2} =
        pin_s2_ff;

    ////////////////////////////////////////////////////////////////////////
    // Master strobe decode
    assign mode     = bwsmp_mode_e'(ctrl_ff[CT_MODE_LSB +: 2]);
    assign cs_act   = ctrl_ff[CT_CSSEL_BIT] ? !cs_b_s2 : !cs_e_s2;
    assign m_rd_act = (mode == BWSMP_SLAVE) && cs_act && !rd_n_s2;
    assign m_wr_end = (mode == BWSMP_SLAVE) && cs_act && wr_n_s2 && !wr_n_d_ff;
    assign m_rd_end = (mode == BWSMP_SLAVE) && cs_act && rd_n_s2 && !rd_n_d_ff;

    // Master read side effects, indexed by address
    always_comb begin
        m_rd_slot = 3'b000;
        if (m_rd_end && maddr_s2 != M_STATUS_IDX) begin
            m_rd_slot[maddr_s2] = 1'b1;
        end
    end

    // Master writes queue up so local accesses can take priority
    bwsmp_fifo #(
        .WIDTH (EVQ_WIDTH),
        .DEPTH (EVQ_DEPTH)
    ) u_evq (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .in_valid  (m_wr_end),
        .in_ready  (evq_in_ready),
        .in_data   ({maddr_s2, mdata_s2}),
        .out_valid (evq_out_valid),
        .out_ready (!loc_busy),
        .out_data  (evq_out_data)
    );

    assign ev_pop            = evq_out_valid && !loc_busy;
    assign {ev_addr, ev_data} = evq_out_data;
    assign m_wr_stat         = ev_pop && (ev_addr == M_STATUS_IDX);

    always_comb begin
        m_wr_slot = 3'b000;
        if (ev_pop && ev_addr != M_STATUS_IDX) begin
            m_wr_slot[ev_addr] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Local bus decode
    assign loc_busy    = loc_wr || loc_rd;
    assign loc_mbx     = (loc_addr >= DATA0_OFS) && (loc_addr <= CONTROL_OFS);
    assign loc_wr_stat = loc_wr && (loc_addr == STATUS_OFS);
    assign loc_wr_slot = {loc_wr && loc_addr == DATA2_OFS, loc_wr && loc_addr == DATA1_OFS,
                          loc_wr && loc_addr == DATA0_OFS};
    assign loc_rd_slot = {loc_rd && loc_addr == DATA2_OFS, loc_rd && loc_addr == DATA1_OFS,
                          loc_rd && loc_addr == DATA0_OFS};

    assign status = {mwrote_ff, in_full_ff, lwrote_ff, out_full_ff};

    // Control register; boot bits stay zero in storage
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= CONTROL_RST;
        end else if (loc_wr && loc_addr == CONTROL_OFS) begin
            ctrl_ff <= {loc_wdata[7], 2'b00, loc_wdata[4:0]};
        end
    end

    // Local read data, one cycle after the read strobe
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            loc_rdata_ff <= DATA_RST;
        end else if (loc_rd) begin
            case (loc_addr)
                DATA0_OFS:   loc_rdata_ff <= in_slot_ff[0];
                DATA1_OFS:   loc_rdata_ff <= in_slot_ff[1];
                DATA2_OFS:   loc_rdata_ff <= in_slot_ff[2];
                STATUS_OFS:  loc_rdata_ff <= status;
                CONTROL_OFS: loc_rdata_ff <= {ctrl_ff[7], boot_s2, ctrl_ff[4], 4'h0};
                PA_DATA_OFS: loc_rdata_ff <= (mode == BWSMP_PA_IN) ? pa_s2 : port_a_out_ff;
                default:     loc_rdata_ff <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data slots in both directions
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 3; i++) begin
                in_slot_ff[i]  <= DATA_RST;
                out_slot_ff[i] <= DATA_RST;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (m_wr_slot[i]) begin
                    in_slot_ff[i] <= ev_data;
                end
                if (loc_wr_slot[i]) begin
                    out_slot_ff[i] <= loc_wdata;
                end
            end
        end
    end

    // Full flags; a set in the clearing cycle wins
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            in_full_ff  <= 3'b000;
            out_full_ff <= 3'b000;
        end else begin
            in_full_ff  <= m_wr_slot | (in_full_ff & ~loc_rd_slot);
            out_full_ff <= loc_wr_slot | (out_full_ff & ~m_rd_slot);
        end
    end

    // Last-writer flags
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mwrote_ff <= 1'b0;
            lwrote_ff <= 1'b0;
        end else begin
            mwrote_ff <= m_wr_slot[0] || (mwrote_ff && !loc_wr_stat);
            lwrote_ff <= loc_wr_slot[0] || (lwrote_ff && !m_wr_stat);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt and attention, cleared by any mailbox access, set wins
    assign set_irq    = m_wr_slot[0] && (ctrl_ff[CT_PRIO_LSB +: 2] != 2'b00);
    assign set_attn   = loc_wr_slot[0];
    assign any_access = (loc_busy && loc_mbx) || ev_pop || m_rd_end;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mailbox_irq_ff     <= 1'b0;
            attention_out_n_ff <= 1'b1;
            irq_priority_ff    <= 2'b00;
            wr_overrun_ff      <= 1'b0;
        end else begin
            mailbox_irq_ff     <= set_irq || (mailbox_irq_ff && !any_access);
            attention_out_n_ff <= !(set_attn || (!attention_out_n_ff && !any_access));
            irq_priority_ff    <= ctrl_ff[CT_PRIO_LSB +: 2];
            wr_overrun_ff      <= !evq_in_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Master data bus drive during a selected read
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_data_out_ff <= 8'h00;
            master_data_oe_ff  <= 1'b0;
        end else begin
            master_data_oe_ff  <= m_rd_act;
            master_data_out_ff <= (maddr_s2 == M_STATUS_IDX) ? status
                                                             : out_slot_ff[maddr_s2];
        end
    end

    // Port A / port B by mode, and boot fetch control
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_a_out_ff     <= 8'h00;
            port_a_oe_ff      <= 1'b0;
            port_b_addr_ff    <= 6'h00;
            port_b_addr_oe_ff <= 1'b0;
            fetch_by_pins_ff  <= 1'b1;
        end else begin
            fetch_by_pins_ff  <= !ctrl_ff[CT_NOFETCH_BIT];
            port_a_oe_ff      <= (mode == BWSMP_PA_OUT) || (mode == BWSMP_EXT_BUS);
            port_b_addr_oe_ff <= (mode == BWSMP_EXT_BUS);
            if (loc_wr && loc_addr == PA_DATA_OFS && mode == BWSMP_PA_OUT) begin
                port_a_out_ff <= loc_wdata;
            end else if (loc_wr && !loc_mbx && mode == BWSMP_EXT_BUS) begin
                port_a_out_ff  <= loc_wdata;
                port_b_addr_ff <= loc_addr[5:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_mwr0;
        m_wr_slot[0] && !loc_wr_stat;
    endsequence
    sequence s_lwr0;
        loc_wr_slot[0] && !m_wr_stat;
    endsequence

    a_stat7_set: assert property (s_mwr0 |=> status[7])
        else $error("status bit7 not set by master write");
    a_stat7_clr: assert property (loc_wr_stat && !m_wr_slot[0] |=> !status[7])
        else $error("status bit7 not cleared");
    a_stat3_set: assert property (s_lwr0 |=> status[3] && $past(loc_wdata) == out_slot_ff[0])
        else $error("status bit3 or slot0 wrong");
    a_in_full: assert property (loc_rd_slot[1] && !m_wr_slot[1] |=> !in_full_ff[1])
        else $error("incoming flag not cleared");
    a_out_full: assert property (m_rd_slot[2] && !loc_wr_slot[2] |=> !status[2])
        else $error("outgoing flag not cleared");
    a_irq_set: assert property (set_irq |=> mailbox_irq_ff)
        else $error("interrupt not raised");
    a_attn_set: assert property (s_lwr0 |=> !attention_out_n_ff)
        else $error("attention not asserted");
    a_clear_any: assert property (any_access && !set_irq && !set_attn
                                  |=> !mailbox_irq_ff && attention_out_n_ff)
        else $error("access did not clear interrupt/attention");
    a_rd_data: assert property (loc_rd && loc_addr == DATA1_OFS
                                |=> loc_rdata_ff == $past(in_slot_ff[1]))
        else $error("local read data mismatch");
    a_fetch_ctl: assert property (ctrl_ff[7] |=> !fetch_by_pins_ff)
        else $error("fetch control not following bit7");
    a_mode_oe: assert property (mode != BWSMP_SLAVE |=> !master_data_oe_ff)
        else $error("master bus driven outside slave mode");
    a_port_dir: assert property ((mode == BWSMP_PA_IN) [*2] |-> !port_a_oe_ff)
        else $error("port A driven in input mode");
endmodule

// [verification/bwsmp_master_model.sv]
// External master on the strobed byte bus of the mailbox port.
// Assumes the bench calls wr and rd; cs_on_b picks the chip-select pin.
`timescale 1ns/1ps
module bwsmp_master_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] master_data_out_ff,
    input  wire logic       master_data_oe_ff,
    output logic      [1:0] master_addr,
    output logic            master_rd_n,
    output logic            master_wr_n,
    output logic      [7:0] master_data_in,
    output logic            port_e_alt_pin,
    output logic            port_b_alt_pin
);
    logic cs_on_b;

    // Idle bus, both selects high
    initial begin
        cs_on_b = 1'b0;
        master_addr = 2'h0;
        master_rd_n = 1'b1;
        master_wr_n = 1'b1;
        master_data_in = 8'h00;
        port_e_alt_pin = 1'b1;
        port_b_alt_pin = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive or release the chosen active-low select
    task automatic sel(input logic on);
        port_e_alt_pin <= ~(on & ~cs_on_b);
        port_b_alt_pin <= ~(on & cs_on_b);
    endtask

    // Write cycle, strobe low and high four cycles or more
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sel(1'b1);
        master_addr <= a;
        master_data_in <= d;
        master_wr_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        master_wr_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sel(1'b0);
        master_data_in <= ~d; // Released bus shows no stale byte
        master_addr <= ~a;
        repeat (3) @(posedge sys_clk);
    endtask

    // Read cycle, data taken at the edge before the strobe rises
    task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic oe);
        @(posedge sys_clk);
        sel(1'b1);
        master_addr <= a;
        master_rd_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        d = master_data_out_ff;
        oe = master_data_oe_ff;
        master_rd_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sel(1'b0);
        master_addr <= ~a;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule

// [verification/tb_bwsmp_top.sv]
// Self-checking bench for the mailbox port: local bus tasks and master model.
// Assumes boot pins at 2'b10, so control reads carry 8'h40.
`timescale 1ns/1ps
module tb_bwsmp_top
    import bwsmp_pkg::*;
;
    logic       sys_clk;
    logic       reset_n;
    logic [7:0] loc_addr;
    logic       loc_wr;
    logic       loc_rd;
    logic [7:0] loc_wdata;
    logic [1:0] boot_mode_pins;
    logic [7:0] port_a_in;
    wire  [7:0] loc_rdata_ff, port_a_out_ff, master_data_out_ff, master_data_in;
    wire  [5:0] port_b_addr_ff;
    wire  [1:0] irq_priority_ff, master_addr;
    wire        master_data_oe_ff, attention_out_n_ff, mailbox_irq_ff, wr_overrun_ff;
    wire        fetch_by_pins_ff, port_a_oe_ff, port_b_addr_oe_ff, e_pin, b_pin;
    wire        master_rd_n, master_wr_n;
    int         failures;
    int         samples_checked;
    int         cycles = 0;
    logic       saw_full = 1'b0;

    bwsmp_top i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .loc_addr(loc_addr),
        .loc_wr(loc_wr), .loc_rd(loc_rd), .loc_wdata(loc_wdata),
        .loc_rdata_ff(loc_rdata_ff), .port_e_alt_pin(e_pin), .port_b_alt_pin(b_pin),
        .master_addr(master_addr), .master_rd_n(master_rd_n), .master_wr_n(master_wr_n),
        .master_data_in(master_data_in), .master_data_out_ff(master_data_out_ff),
        .master_data_oe_ff(master_data_oe_ff), .attention_out_n_ff(attention_out_n_ff),
        .mailbox_irq_ff(mailbox_irq_ff), .irq_priority_ff(irq_priority_ff),
        .wr_overrun_ff(wr_overrun_ff), .boot_mode_pins(boot_mode_pins),
        .fetch_by_pins_ff(fetch_by_pins_ff), .port_a_in(port_a_in),
        .port_a_out_ff(port_a_out_ff), .port_a_oe_ff(port_a_oe_ff),
        .port_b_addr_ff(port_b_addr_ff), .port_b_addr_oe_ff(port_b_addr_oe_ff));

    bwsmp_master_model i_master (.sys_clk(sys_clk), .master_data_out_ff(master_data_out_ff),
        .master_data_oe_ff(master_data_oe_ff), .master_addr(master_addr),
        .master_rd_n(master_rd_n), .master_wr_n(master_wr_n),
        .master_data_in(master_data_in), .port_e_alt_pin(e_pin), .port_b_alt_pin(b_pin));

    ////////////////////////////////////////////////////////////////////////
    // Clock, hang limit and full-queue watch
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (wr_overrun_ff === 1'b1) saw_full <= 1'b1;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Local write, effects settled on return
    task automatic lw(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        loc_addr <= a;
        loc_wdata <= d;
        loc_wr <= 1'b1;
        @(posedge sys_clk);
        loc_wr <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    // Local read and compare
    task automatic lc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        loc_addr <= a;
        loc_rd <= 1'b1;
        @(posedge sys_clk);
        loc_rd <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(loc_rdata_ff, exp);
    endtask

    // Master read and compare, bus must be driven
    task automatic mc(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       oe;
        i_master.rd(a, d, oe);
        chk(oe, 8'h01);
        chk(d, exp);
    endtask

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {loc_addr, loc_wr, loc_rd, loc_wdata} = '0;
        boot_mode_pins = 2'b10;
        port_a_in = 8'h3C;
        reset_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Let boot and master pins pass both sync stages
        repeat (2) @(posedge sys_clk);
        lc(CONTROL_OFS, 8'h40);
        chk(fetch_by_pins_ff, 8'h01);
        lc(STATUS_OFS, 8'h00);
        lc(PA_DATA_OFS, 8'h3C);
        chk(port_a_oe_ff, 8'h00);
        lc(8'h40, 8'h00);
        lw(DATA2_OFS, 8'hC2);
        lw(DATA1_OFS, 8'hC1);
        chk(attention_out_n_ff, 8'h01);
        lw(DATA0_OFS, 8'hC0);
        chk(attention_out_n_ff, 8'h00);
        lc(STATUS_OFS, 8'h0F);
        chk(attention_out_n_ff, 8'h01);
        lw(CONTROL_OFS, 8'h08);
        mc(2'd0, 8'hC0);
        mc(2'd1, 8'hC1);
        mc(2'd2, 8'hC2);
        lc(STATUS_OFS, 8'h08);
        mc(M_STATUS_IDX, 8'h08);
        i_master.wr(M_STATUS_IDX, 8'h00);
        lc(STATUS_OFS, 8'h00);
        for (int p = 0; p < 4; p++) begin
            lw(CONTROL_OFS, 8'h08 | 8'(p));
            chk(irq_priority_ff, 8'(p));
            lc(CONTROL_OFS, 8'h40);
        end
        i_master.wr(2'd2, 8'hA2);
        i_master.wr(2'd1, 8'hA1);
        chk(mailbox_irq_ff, 8'h00);
        i_master.wr(2'd0, 8'hA0);
        chk(mailbox_irq_ff, 8'h01);
        lc(STATUS_OFS, 8'hF0);
        chk(mailbox_irq_ff, 8'h00);
        lc(DATA0_OFS, 8'hA0);
        lc(DATA1_OFS, 8'hA1);
        lc(DATA2_OFS, 8'hA2);
        lc(STATUS_OFS, 8'h80);
        lw(STATUS_OFS, 8'h00);
        lc(STATUS_OFS, 8'h00);
        lw(CONTROL_OFS, 8'h08);
        i_master.wr(2'd0, 8'h55);
        chk(mailbox_irq_ff, 8'h00);
        lc(DATA0_OFS, 8'h55);
        lw(CONTROL_OFS, 8'h18);
        i_master.cs_on_b = 1'b1;
        i_master.wr(2'd1, 8'h5A);
        lc(DATA1_OFS, 8'h5A);
        i_master.cs_on_b = 1'b0;
        i_master.wr(2'd1, 8'h3B);
        lc(DATA1_OFS, 8'h5A);
        // Local reads every cycle stall the queue until it refuses
        i_master.cs_on_b = 1'b1;
        @(posedge sys_clk);
        loc_addr <= STATUS_OFS;
        loc_rd <= 1'b1;
        for (int i = 1; i <= 17; i++) i_master.wr(2'd2, 8'(i));
        chk(saw_full, 8'h01);
        loc_rd <= 1'b0;
        repeat (40) @(posedge sys_clk);
        #1;
        chk(wr_overrun_ff, 8'h00);
        lc(DATA2_OFS, 8'h10);
        lw(CONTROL_OFS, 8'h00);
        i_master.wr(2'd2, 8'h77);
        lc(DATA2_OFS, 8'h10);
        lw(CONTROL_OFS, 8'h04);
        lw(PA_DATA_OFS, 8'h96);
        chk(port_a_out_ff, 8'h96);
        chk(port_a_oe_ff, 8'h01);
        lw(CONTROL_OFS, 8'h0C);
        lw(8'h15, 8'h4B);
        chk(port_a_out_ff, 8'h4B);
        chk(port_b_addr_ff, 8'h15);
        chk({port_a_oe_ff, port_b_addr_oe_ff}, 8'h03);
        lw(CONTROL_OFS, 8'hE0);
        chk(fetch_by_pins_ff, 8'h00);
        lc(CONTROL_OFS, 8'hC0);
        close_out();
    end
endmodule
